// ---- logic/rsif_pkg.sv ----
// Constants, register map and carrier types of the receive system interface formatter
// Operation
// R1: Derive reference clock, 1.544 or 2.048 MHz
// R2: Single rail drives decoded data on active edge
// R3: One pin: single data or positive data
// R4: Bit b3 inverts all data output levels
// R5: Powered down: single data float or low
// R6: Powered down: both rails float or low
// R7: Dual NRZ: undecoded rails on active edge
// R8: Dual RZ: undecoded RZ rails on active edge
// R9: Sliced: raw pulses out, no clock output
// R10: Differential: tip and ring opposite pulses
// R11: Single ended: tip pulse sign alone
// R12: Recovered clock out except in sliced mode
// R13: Bit b4 selects rising or falling active edge
// R14: In loss: clock held high or reference
// R15: Powered down: clock floats or drives low
// R16: Serial loss status, seventeen slots, start marker
// R17: Serial status changes on rising, active high
// R18: Status clock disabled: serial output floats
// R19: Filler first, then channels 0 to 15
// R20: Far end samples falling edge, resyncs marker
`default_nettype none

package rsif_pkg;

	// ****************************************
	// Sizes and clocking
	// ****************************************
	localparam int NCH = 16;
	localparam int SLOTS = 17;
	localparam longint SYS_CLK_HZ = 200000000;
	localparam longint T1_REF_HZ = 1544000;
	localparam longint E1_REF_HZ = 2048000;
	localparam longint STAT_CLK_HZ = 2048000;
	// Phase increments of 32-bit accumulators, fraction of the system clock
	localparam logic [31:0] T1_INC = 32'((T1_REF_HZ << 32) / SYS_CLK_HZ);
	localparam logic [31:0] E1_INC = 32'((E1_REF_HZ << 32) / SYS_CLK_HZ);
	localparam logic [31:0] STAT_INC = 32'((STAT_CLK_HZ << 32) / SYS_CLK_HZ);

	// ****************************************
	// Register map: address[7:4] kind, address[3:0] channel
	// ****************************************
	localparam logic [3:0] KIND_CFG_A = 4'h0;
	localparam logic [3:0] KIND_CFG_B = 4'h1;
	localparam logic [3:0] KIND_CTRL = 4'h2;
	localparam logic [3:0] KIND_LOS = 4'hE;
	localparam logic [3:0] KIND_GLOBAL = 4'hF;
	localparam logic [7:0] CFG_A_RESET = 8'h00;
	localparam logic [7:0] CFG_B_RESET = 8'h00;
	localparam logic [7:0] GLOBAL_RESET = 8'h00;
	// Field positions
	localparam int BIT_FMT_LO = 0;
	localparam int BIT_INVERT = 3;
	localparam int BIT_EDGE = 4;
	localparam int BIT_PD_FLOAT = 6;
	localparam int BIT_LOS_HOLD = 7;
	localparam int BIT_POWERDOWN = 0;
	localparam int BIT_SINGLE_END = 1;
	localparam int BIT_E1 = 0;
	localparam int BIT_STAT_EN = 1;

	typedef enum logic [1:0] {
		RSIF_SINGLE_NRZ,
		RSIF_DUAL_NRZ,
		RSIF_DUAL_RZ,
		RSIF_DUAL_SLICED
	} rsif_fmt_t;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rsif_regreq_t;

	typedef struct packed {
		logic [NCH-1:0] tip_pos;
		logic [NCH-1:0] tip_neg;
		logic [NCH-1:0] ring_pos;
		logic [NCH-1:0] ring_neg;
	} rsif_slice_t;

endpackage : rsif_pkg

`default_nettype wire

// ---- logic/rsif_top.sv ----
// Receive system-side formatter for sixteen line channels and serial loss status
`timescale 1ns/1ps
`default_nettype none

module rsif_top (
	// Clock and reset
	input  wire  logic                          sys_clk,
	input  wire  logic                          rst_n,
	// Register port
	input  wire  rsif_pkg::rsif_regreq_t        reg_req,
	output logic [15:0]                         reg_rdata,
	// Line side, per channel, foreign domain
	input  wire  logic [rsif_pkg::NCH-1:0]      rx_rec_clk_in,
	input  wire  logic [rsif_pkg::NCH-1:0]      rx_decoded_data,
	input  wire  rsif_pkg::rsif_slice_t         line_rx_tip_ring,
	input  wire  logic [rsif_pkg::NCH-1:0]      line_los_in,
	// System side data, pin doubles as single data
	output logic [rsif_pkg::NCH-1:0]            rx_pos_data_out,
	output logic [rsif_pkg::NCH-1:0]            rx_pos_data_oe_n,
	output logic [rsif_pkg::NCH-1:0]            rx_neg_data_out,
	output logic [rsif_pkg::NCH-1:0]            rx_neg_data_oe_n,
	output logic [rsif_pkg::NCH-1:0]            rx_recovered_clock_out,
	output logic [rsif_pkg::NCH-1:0]            rx_recovered_clock_oe_n,
	// Reference and serial status
	output logic                                derived_ref_clock,
	output logic                                status_clock_out,
	output logic                                serial_los_status_out,
	output logic                                serial_los_status_oe_n,
	output logic                                serial_los_start_marker
);

	localparam int N = rsif_pkg::NCH;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [N-1:0]      clk_s1;
		logic [N-1:0]      clk_s2;
		logic [N-1:0]      clk_s3;
		logic [N-1:0]      dat_s1;
		logic [N-1:0]      dat_s2;
		logic [4*N-1:0]    sl_s1;
		logic [4*N-1:0]    sl_s2;
		logic [N-1:0]      los_s1;
		logic [N-1:0]      los_s2;
		logic [N-1:0]      nrz_single;
		logic [N-1:0]      nrz_pos;
		logic [N-1:0]      nrz_neg;
		logic [N-1:0][7:0] cfg_a;
		logic [N-1:0][7:0] cfg_b;
		logic [N-1:0][7:0] ctrl;
		logic [7:0]        glb;
		logic [31:0]       acc_ref;
		logic [31:0]       acc_st;
		logic              st_d;
		logic [4:0]        slot;
		logic              los_bit;
		logic              marker;
		logic [15:0]       rdata;
	} rsif_state_t;

	rsif_state_t s;
	rsif_state_t next_s;
	logic        rst_m;
	logic        rst_sync;

	// ****************************************
	// Reset release
	// ****************************************
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_m <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_m <= 1'b1;
			rst_sync <= rst_m;
		end
	end

	// ****************************************
	// Per-channel decode
	// ****************************************
	logic [N-1:0] act_edge;
	logic [N-1:0] pos_pulse;
	logic [N-1:0] neg_pulse;
	logic [N-1:0] pd;
	logic [N-1:0] flt;
	logic [N-1:0] inv;
	logic [N-1:0] sliced;
	logic         st_rise;

	assign st_rise = s.acc_st[31] & ~s.st_d;

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_ch
			rsif_pkg::rsif_fmt_t fmt;
			logic tp;
			logic tn;
			logic rp;
			logic rn;
			logic phase;
			logic pos_raw;
			logic neg_raw;
			logic rise;
			logic fall;

			assign fmt = rsif_pkg::rsif_fmt_t'(s.cfg_b[g][rsif_pkg::BIT_FMT_LO +: 2]);
			assign tp = s.sl_s2[g];
			assign tn = s.sl_s2[N+g];
			assign rp = s.sl_s2[2*N+g];
			assign rn = s.sl_s2[3*N+g];
			assign rise = s.clk_s2[g] & ~s.clk_s3[g];
			assign fall = ~s.clk_s2[g] & s.clk_s3[g];
			// Active edge choice per channel
			assign act_edge[g] = s.cfg_b[g][rsif_pkg::BIT_EDGE] ? fall : rise; // [R13]
			// Single ended ignores ring; differential needs opposite ring pulse
			assign pos_pulse[g] = s.ctrl[g][rsif_pkg::BIT_SINGLE_END] ? tp : (tp & rn); // [R10] [R11]
			assign neg_pulse[g] = s.ctrl[g][rsif_pkg::BIT_SINGLE_END] ? tn : (tn & rp); // [R10] [R11]
			assign pd[g] = s.ctrl[g][rsif_pkg::BIT_POWERDOWN];
			assign flt[g] = s.cfg_a[g][rsif_pkg::BIT_PD_FLOAT];
			assign inv[g] = s.cfg_b[g][rsif_pkg::BIT_INVERT];
			assign sliced[g] = (fmt == rsif_pkg::RSIF_DUAL_SLICED);
			// RZ returns to zero in the second half of the bit
			assign phase = s.cfg_b[g][rsif_pkg::BIT_EDGE] ? ~s.clk_s2[g] : s.clk_s2[g];

			always_comb begin
				case (fmt)
					rsif_pkg::RSIF_SINGLE_NRZ: begin
						pos_raw = s.nrz_single[g]; // [R2] [R3]
						neg_raw = 1'b0;
					end
					rsif_pkg::RSIF_DUAL_NRZ: begin
						pos_raw = s.nrz_pos[g]; // [R7]
						neg_raw = s.nrz_neg[g];
					end
					rsif_pkg::RSIF_DUAL_RZ: begin
						pos_raw = s.nrz_pos[g] & phase; // [R8]
						neg_raw = s.nrz_neg[g] & phase;
					end
					default: begin
						pos_raw = pos_pulse[g]; // [R9]
						neg_raw = neg_pulse[g];
					end
				endcase
			end

			// Powered down: drive low, or release when float is selected
			assign rx_pos_data_out[g] = pd[g] ? 1'b0 : (pos_raw ^ inv[g]); // [R4] [R5]
			assign rx_neg_data_out[g] = pd[g] ? 1'b0 : (neg_raw ^ inv[g]); // [R4] [R6]
			assign rx_pos_data_oe_n[g] = pd[g] & flt[g]; // [R5]
			assign rx_neg_data_oe_n[g] = pd[g] & flt[g]; // [R6]
			assign rx_recovered_clock_oe_n[g] = pd[g] & flt[g]; // [R15]

			always_comb begin
				if (pd[g] || sliced[g]) begin
					rx_recovered_clock_out[g] = 1'b0; // [R9] [R15]
				end else if (s.los_s2[g]) begin
					rx_recovered_clock_out[g] = s.cfg_a[g][rsif_pkg::BIT_LOS_HOLD] ?
						1'b1 : derived_ref_clock; // [R14]
				end else begin
					rx_recovered_clock_out[g] = s.clk_s2[g]; // [R12]
				end
			end
		end
	endgenerate

	assign derived_ref_clock = s.acc_ref[31];
	assign status_clock_out = s.glb[rsif_pkg::BIT_STAT_EN] & s.st_d;
	assign serial_los_status_out = s.los_bit;
	assign serial_los_status_oe_n = ~s.glb[rsif_pkg::BIT_STAT_EN]; // [R18]
	assign serial_los_start_marker = s.marker;
	assign reg_rdata = s.rdata;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_s = s;
		next_s.rdata = 16'h0000;
		// Two-flop synchronisers; stage one feeds stage two only
		next_s.clk_s1 = rx_rec_clk_in;
		next_s.clk_s2 = s.clk_s1;
		next_s.clk_s3 = s.clk_s2;
		next_s.dat_s1 = rx_decoded_data;
		next_s.dat_s2 = s.dat_s1;
		next_s.sl_s1 = {line_rx_tip_ring.ring_neg, line_rx_tip_ring.ring_pos,
			line_rx_tip_ring.tip_neg, line_rx_tip_ring.tip_pos};
		next_s.sl_s2 = s.sl_s1;
		next_s.los_s1 = line_los_in;
		next_s.los_s2 = s.los_s1;
		// Fractional dividers give jitter of one system clock; truncated increments run slightly slow
		next_s.acc_ref = s.acc_ref + (s.glb[rsif_pkg::BIT_E1] ?
			rsif_pkg::E1_INC : rsif_pkg::T1_INC); // [R1]
		next_s.acc_st = s.acc_st + rsif_pkg::STAT_INC;
		next_s.st_d = s.acc_st[31];
		for (int c = 0; c < N; c++) begin
			if (act_edge[c]) begin
				next_s.nrz_single[c] = s.dat_s2[c]; // [R2]
				next_s.nrz_pos[c] = pos_pulse[c]; // [R7] [R8]
				next_s.nrz_neg[c] = neg_pulse[c]; // [R7] [R8]
			end
		end
		// Serial status frame: slot 0 filler, then channels in order
		if (!s.glb[rsif_pkg::BIT_STAT_EN]) begin
			next_s.slot = 5'h00;
			next_s.los_bit = 1'b0;
			next_s.marker = 1'b0;
		end else if (st_rise) begin // [R17]
			if (s.slot == 5'(rsif_pkg::SLOTS - 1)) begin
				next_s.slot = 5'h00;
			end else begin
				next_s.slot = s.slot + 5'h01;
			end
			if (s.slot == 5'h00) begin
				next_s.los_bit = 1'b0; // [R16] [R19]
				next_s.marker = 1'b1;
			end else begin
				next_s.los_bit = s.los_s2[s.slot[3:0] - 4'h1]; // [R16] [R19]
				next_s.marker = 1'b0;
			end
		end
		if (reg_req.wr) begin
			case (reg_req.addr[7:4])
				rsif_pkg::KIND_CFG_A: next_s.cfg_a[reg_req.addr[3:0]] = reg_req.wdata;
				rsif_pkg::KIND_CFG_B: next_s.cfg_b[reg_req.addr[3:0]] = reg_req.wdata;
				rsif_pkg::KIND_CTRL: next_s.ctrl[reg_req.addr[3:0]] = reg_req.wdata;
				rsif_pkg::KIND_GLOBAL: next_s.glb = reg_req.wdata;
				default: ;
			endcase
		end
		if (reg_req.rd) begin
			case (reg_req.addr[7:4])
				rsif_pkg::KIND_CFG_A: next_s.rdata = {8'h00, s.cfg_a[reg_req.addr[3:0]]};
				rsif_pkg::KIND_CFG_B: next_s.rdata = {8'h00, s.cfg_b[reg_req.addr[3:0]]};
				rsif_pkg::KIND_CTRL: next_s.rdata = {8'h00, s.ctrl[reg_req.addr[3:0]]};
				rsif_pkg::KIND_LOS: next_s.rdata = s.los_s2;
				rsif_pkg::KIND_GLOBAL: next_s.rdata = {8'h00, s.glb};
				default: next_s.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			s <= '0;
			for (int c = 0; c < N; c++) begin
				s.cfg_a[c] <= rsif_pkg::CFG_A_RESET;
				s.cfg_b[c] <= rsif_pkg::CFG_B_RESET;
			end
			s.glb <= rsif_pkg::GLOBAL_RESET;
		end else begin
			s <= next_s;
		end
	end

	// ****************************************
	// Checks on channel 0 and the status link
	// ****************************************
	logic [3:0] ch0_kind;
	assign ch0_kind = 4'(s.cfg_b[0][1:0]);
	// Channel status that the current slot carries
	logic       slot_los;
	assign slot_los = s.los_s2[s.slot[3:0] - 4'h1];

	sequence s_quiet_cfg;
		$stable(s.cfg_b[0]) && $stable(s.ctrl[0]) && $stable(s.cfg_a[0]);
	endsequence

	property p_single_on_edge;
		@(posedge sys_clk) disable iff (!rst_sync)
		((ch0_kind == 4'h0 && !pd[0] && $changed(rx_pos_data_out[0])) and s_quiet_cfg)
			|-> $past(act_edge[0]);
	endproperty
	a_single_on_edge: assert property (p_single_on_edge) // [R2]
		else $error("single data changed without active edge");

	property p_invert;
		@(posedge sys_clk) disable iff (!rst_sync)
		// Expected level from the synchronised input, not from the held copy
		(ch0_kind == 4'h0 && !pd[0] && act_edge[0]) ##1 s_quiet_cfg
			|-> (rx_pos_data_out[0] == ($past(s.dat_s2[0]) ^ inv[0]));
	endproperty
	a_invert: assert property (p_invert) // [R4]
		else $error("data level not following invert bit");

	property p_pd_data;
		@(posedge sys_clk) disable iff (!rst_sync)
		pd[0] |-> (rx_pos_data_out[0] == 1'b0 && rx_neg_data_out[0] == 1'b0
			&& rx_pos_data_oe_n[0] == flt[0] && rx_neg_data_oe_n[0] == flt[0]);
	endproperty
	a_pd_data: assert property (p_pd_data) // [R5] [R6]
		else $error("powered down data pins wrong");

	property p_dual_on_edge;
		@(posedge sys_clk) disable iff (!rst_sync)
		((ch0_kind == 4'h1 && !pd[0] && $changed(rx_neg_data_out[0])) and s_quiet_cfg)
			|-> $past(act_edge[0]);
	endproperty
	a_dual_on_edge: assert property (p_dual_on_edge) // [R7]
		else $error("dual rail data changed without active edge");

	property p_sliced;
		@(posedge sys_clk) disable iff (!rst_sync)
		(sliced[0] && !pd[0]) |-> (rx_recovered_clock_out[0] == 1'b0
			&& rx_pos_data_out[0] == (pos_pulse[0] ^ inv[0]));
	endproperty
	a_sliced: assert property (p_sliced) // [R9]
		else $error("sliced mode output wrong");

	property p_los_hold;
		@(posedge sys_clk) disable iff (!rst_sync)
		(s.los_s2[0] && !pd[0] && !sliced[0] && s.cfg_a[0][7]) |-> rx_recovered_clock_out[0];
	endproperty
	a_los_hold: assert property (p_los_hold) // [R14]
		else $error("clock not held high in loss");

	property p_pd_clock;
		@(posedge sys_clk) disable iff (!rst_sync)
		pd[0] |-> (!rx_recovered_clock_out[0] && rx_recovered_clock_oe_n[0] == flt[0]);
	endproperty
	a_pd_clock: assert property (p_pd_clock) // [R15]
		else $error("powered down clock pin wrong");

	property p_serial_on_rise;
		@(posedge sys_clk) disable iff (!rst_sync)
		($changed(serial_los_status_out) && $past(s.glb[1]) && s.glb[1])
			|-> $rose(status_clock_out);
	endproperty
	a_serial_on_rise: assert property (p_serial_on_rise) // [R17]
		else $error("serial status changed off rising edge");

	property p_float_off;
		@(posedge sys_clk) disable iff (!rst_sync)
		!s.glb[1] |-> (serial_los_status_oe_n && !status_clock_out);
	endproperty
	a_float_off: assert property (p_float_off) // [R18]
		else $error("serial status driven while disabled");

	property p_filler_first;
		@(posedge sys_clk) disable iff (!rst_sync)
		$rose(serial_los_start_marker) |-> (!serial_los_status_out && s.slot == 5'h01);
	endproperty
	a_filler_first: assert property (p_filler_first) // [R16] [R19]
		else $error("start filler misplaced");

	property p_slot_bit;
		@(posedge sys_clk) disable iff (!rst_sync)
		(st_rise && s.glb[1] && s.slot != 5'h00) |=>
			(serial_los_status_out == $past(slot_los));
	endproperty
	a_slot_bit: assert property (p_slot_bit) // [R16] [R19]
		else $error("serial bit not the channel status");

	property p_los_ref;
		@(posedge sys_clk) disable iff (!rst_sync)
		(s.los_s2[0] && !pd[0] && !sliced[0] && !s.cfg_a[0][rsif_pkg::BIT_LOS_HOLD])
			|-> (rx_recovered_clock_out[0] == derived_ref_clock);
	endproperty
	a_los_ref: assert property (p_los_ref) // [R14]
		else $error("loss clock not the reference clock");

	property p_rz_low_half;
		@(posedge sys_clk) disable iff (!rst_sync)
		(ch0_kind == 4'h2 && !pd[0] && !s.cfg_b[0][rsif_pkg::BIT_EDGE] && !s.clk_s2[0])
			|-> (rx_pos_data_out[0] == inv[0] && rx_neg_data_out[0] == inv[0]);
	endproperty
	a_rz_low_half: assert property (p_rz_low_half) // [R8]
		else $error("return to zero rails not idle in low half");

	property p_single_neg_idle;
		@(posedge sys_clk) disable iff (!rst_sync)
		(ch0_kind == 4'h0 && !pd[0]) |-> (rx_neg_data_out[0] == inv[0]);
	endproperty
	a_single_neg_idle: assert property (p_single_neg_idle) // [R3]
		else $error("negative rail active in single rail mode");

endmodule : rsif_top

`default_nettype wire

// ---- verif/rsif_far_end.sv ----
// Far-end system receiver model that collects the serial loss status frames
`timescale 1ns/1ps
`default_nettype none

module rsif_far_end (
	// Clock and reset
	input  wire  logic        sys_clk,
	input  wire  logic        rst_n,
	// Serial status from the block
	input  wire  logic        status_clock_out,
	input  wire  logic        serial_los_status_out,
	input  wire  logic        serial_los_start_marker,
	// Collected results
	output logic [15:0]       frame_vec,
	output logic [7:0]        frame_cnt,
	output logic [7:0]        err_cnt
);
	logic        clk_q;
	logic        dat_q;
	logic [4:0]  slot;
	logic [15:0] acc;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_q <= 1'b0;
			dat_q <= 1'b0;
			slot <= 5'h00;
			acc <= 16'h0000;
			frame_vec <= 16'h0000;
			frame_cnt <= 8'h00;
			err_cnt <= 8'h00;
		end else begin
			clk_q <= status_clock_out;
			dat_q <= serial_los_status_out;
			// Serial bit may move only with a status clock rise
			if (serial_los_status_out != dat_q && !(status_clock_out && !clk_q)) begin
				err_cnt <= err_cnt + 8'h01;
			end
			// Sample on the falling edge, resync on the marker
			if (clk_q && !status_clock_out) begin
				if (serial_los_start_marker) begin
					if (slot != 5'h00 && slot != 5'h11) begin
						err_cnt <= err_cnt + 8'h01;
					end
					slot <= 5'h01;
				end else if (slot != 5'h00 && slot < 5'h11) begin
					acc[4'(slot - 5'h01)] <= serial_los_status_out;
					slot <= slot + 5'h01;
					if (slot == 5'h10) begin
						frame_vec <= {serial_los_status_out, acc[14:0]};
						frame_cnt <= frame_cnt + 8'h01;
					end
				end
			end
		end
	end

endmodule : rsif_far_end

`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the receive system interface formatter
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic                   sys_clk = 1'b0;
	logic                   rst_n = 1'b0;
	logic                   lclk = 1'b0;
	logic                   lclk_en = 1'b0;
	rsif_pkg::rsif_regreq_t req = '0;
	rsif_pkg::rsif_slice_t  slc = '0;
	logic [15:0]            dec = 16'h0000;
	logic [15:0]            los = 16'h0000;
	logic [15:0]            rdata, pos, pos_oe_n, neg, neg_oe_n, rclk, rclk_oe_n;
	logic                   ref_clk, stat_clk, ser, ser_oe_n, marker;
	logic [15:0]            frame_vec;
	logic [7:0]             frame_cnt, far_err;
	int                     failures = 0;
	int                     samples_checked = 0;
	int                     ref_rises = 0;
	int                     rc_rises = 0;
	int                     dr, dc, k;

	always #2.5 sys_clk = ~sys_clk;
	// Link clock, phase unrelated to sys_clk
	initial #1.3 forever #62.5 lclk = lclk_en ? ~lclk : 1'b0;
	always @(posedge ref_clk) ref_rises++;
	always @(posedge rclk[15]) rc_rises++;

	rsif_top uut (
		.sys_clk(sys_clk), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata),
		.rx_rec_clk_in({16{lclk}}), .rx_decoded_data(dec), .line_rx_tip_ring(slc),
		.line_los_in(los), .rx_pos_data_out(pos), .rx_pos_data_oe_n(pos_oe_n),
		.rx_neg_data_out(neg), .rx_neg_data_oe_n(neg_oe_n),
		.rx_recovered_clock_out(rclk), .rx_recovered_clock_oe_n(rclk_oe_n),
		.derived_ref_clock(ref_clk), .status_clock_out(stat_clk),
		.serial_los_status_out(ser), .serial_los_status_oe_n(ser_oe_n),
		.serial_los_start_marker(marker)
	);

	rsif_far_end far (
		.sys_clk(sys_clk), .rst_n(rst_n), .status_clock_out(stat_clk),
		.serial_los_status_out(ser), .serial_los_start_marker(marker),
		.frame_vec(frame_vec), .frame_cnt(frame_cnt), .err_cnt(far_err)
	);

	// ****************************************
	// Tasks
	// ****************************************
	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge sys_clk);
		req <= '0;
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge sys_clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge sys_clk);
		req <= '0;
		#1;
		chk(rdata, exp);
	endtask : reg_rd

	task automatic cfg_all(input logic [3:0] kind, input logic [7:0] d);
		for (int c = 0; c < 16; c++) begin
			reg_wr({kind, 4'(c)}, d);
		end
	endtask : cfg_all

	// Bounded search for a link clock level change, seen on sys_clk edges
	task automatic seek_lclk(input logic lvl);
		int n;
		n = 0;
		while (n < 200 && lclk !== ~lvl) begin
			@(posedge sys_clk);
			n++;
		end
		while (n < 200 && lclk !== lvl) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 200) begin
			failures++;
			report_and_stop();
		end
	endtask : seek_lclk

	// Change line inputs mid low half, clear of both clock edges
	task automatic put(input logic [15:0] d, input rsif_pkg::rsif_slice_t s);
		seek_lclk(1'b0);
		repeat (6) @(posedge sys_clk);
		dec <= d;
		slc <= s;
	endtask : put

	task automatic wait_edge(input logic rise);
		seek_lclk(rise);
		repeat (8) @(posedge sys_clk);
		#1;
	endtask : wait_edge

	task automatic rates;
		dr = ref_rises;
		dc = rc_rises;
		repeat (2000) @(posedge sys_clk);
		dr = ref_rises - dr;
		dc = rc_rises - dc;
	endtask : rates

	function automatic logic [15:0] in_rate(input int got, input longint hz);
		int e;
		e = int'(2000 * hz / rsif_pkg::SYS_CLK_HZ);
		return 16'(got >= e && got <= e + 1);
	endfunction : in_rate

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		reg_rd(8'h10, 16'h0000);
		reg_rd(8'h50, 16'h0000);
		chk(16'(ser_oe_n), 16'h0001);
		rates();
		chk(in_rate(dr, rsif_pkg::T1_REF_HZ), 16'h0001);
		reg_wr(8'hF0, 8'h01);
		rates();
		chk(in_rate(dr, rsif_pkg::E1_REF_HZ), 16'h0001);
		reg_wr(8'hF0, 8'h00);
		lclk_en <= 1'b1;
		put(16'h5A3C, '0);
		wait_edge(1'b1);
		chk(pos, 16'h5A3C);
		chk(neg, 16'h0000);
		chk(rclk, 16'hFFFF);
		wait_edge(1'b0);
		chk(rclk, 16'h0000);
		cfg_all(4'h1, 8'h08);
		put(16'h0F0F, '0);
		wait_edge(1'b1);
		chk(pos, 16'hF0F0);
		chk(neg, 16'hFFFF);
		// Falling active edge: nothing moves at the rise
		cfg_all(4'h1, 8'h10);
		put(16'hC3A5, '0);
		wait_edge(1'b1);
		chk(pos, 16'h0F0F);
		wait_edge(1'b0);
		chk(pos, 16'hC3A5);
		cfg_all(4'h1, 8'h01);
		put(16'h0000, '{tip_pos: 16'h00FF, tip_neg: 16'hFF00, ring_pos: 16'hFF00,
			ring_neg: 16'h00FF});
		wait_edge(1'b1);
		chk(pos, 16'h00FF);
		chk(neg, 16'hFF00);
		// Ring wired against a differential reading
		cfg_all(4'h2, 8'h02);
		put(16'h0000, '{tip_pos: 16'h3355, tip_neg: 16'h0CA0, ring_pos: 16'h3355,
			ring_neg: 16'h0CA0});
		wait_edge(1'b1);
		chk(pos, 16'h3355);
		chk(neg, 16'h0CA0);
		cfg_all(4'h2, 8'h00);
		cfg_all(4'h1, 8'h02);
		put(16'h0000, '{tip_pos: 16'h1234, tip_neg: 16'h4001, ring_pos: 16'h4001,
			ring_neg: 16'h1234});
		wait_edge(1'b1);
		chk(pos, 16'h1234);
		chk(neg, 16'h4001);
		wait_edge(1'b0);
		chk(pos, 16'h0000);
		cfg_all(4'h1, 8'h03);
		put(16'h0000, '{tip_pos: 16'h00FF, tip_neg: 16'hFF00, ring_pos: 16'hFF00,
			ring_neg: 16'h00FF});
		wait_edge(1'b1);
		chk(pos, 16'h00FF);
		chk(rclk, 16'h0000);
		cfg_all(4'h1, 8'h00);
		cfg_all(4'h0, 8'h40);
		cfg_all(4'h2, 8'h01);
		repeat (4) @(posedge sys_clk);
		chk(pos_oe_n, 16'hFFFF);
		chk(neg_oe_n, 16'hFFFF);
		chk(rclk_oe_n, 16'hFFFF);
		cfg_all(4'h0, 8'h00);
		repeat (4) @(posedge sys_clk);
		chk(pos_oe_n | pos, 16'h0000);
		chk(neg_oe_n | neg, 16'h0000);
		chk(rclk_oe_n | rclk, 16'h0000);
		cfg_all(4'h2, 8'h00);
		// Loss channels hold high through the low half
		los <= 16'h9C35;
		cfg_all(4'h0, 8'h80);
		reg_rd(8'hE0, 16'h9C35);
		wait_edge(1'b0);
		chk(rclk, 16'h9C35);
		lclk_en <= 1'b0;
		cfg_all(4'h0, 8'h00);
		rates();
		chk(in_rate(dc, rsif_pkg::T1_REF_HZ), 16'h0001);
		reg_wr(8'hF0, 8'h02);
		repeat (2) @(posedge sys_clk);
		chk(16'(ser_oe_n), 16'h0000);
		for (k = 0; k < 5000 && frame_cnt < 8'h02; k++) begin
			@(posedge sys_clk);
		end
		if (frame_cnt < 8'h02) begin
			failures++;
			report_and_stop();
		end
		chk(frame_vec, 16'h9C35);
		chk(16'(far_err), 16'h0000);
		reg_wr(8'hF0, 8'h00);
		repeat (3) @(posedge sys_clk);
		chk(16'(ser_oe_n), 16'h0001);
		report_and_stop();
	end

	initial begin
		repeat (60000) @(posedge sys_clk);
		failures++;
		report_and_stop();
	end

endmodule : testbench

`default_nettype wire
